// *** core/mdc_regs.sv ***
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ns
module mdc_regs #(
  parameter int W = 16 // Sample width.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic hready, // Bus ready.
  input wire logic [31:0] hwdata, // Write data.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  input wire logic [W-1:0] sample_a, // Channel A sample.
  input wire logic [W-1:0] sample_b, // Channel B sample.
  input wire logic ovr_a, // Channel A fast overrange flag.
  input wire logic ovr_b, // Channel B fast overrange flag.
  output logic [W-1:0] out_a, // Channel A output.
  output logic [W-1:0] out_b, // Channel B output.
  output logic [2:0] nyquist_zone, // Active zone code.
  output logic zone_valid, // Zone selection active and legal.
  output logic digital_block_soft_reset // Soft reset of the datapath.
);
  logic [7:0] zone_sel_reg, zone_sel_next;
  logic [7:0] gain_reg, gain_next;
  logic [7:0] zone_ctrl_reg, zone_ctrl_next;
  logic [7:0] unlock_a_reg, unlock_a_next;
  logic [7:0] unlock_b_reg, unlock_b_next;
  logic [7:0] lsb_en_reg, lsb_en_next;
  logic [7:0] lsb_src_reg, lsb_src_next;
  logic [7:0] output_bit_permutation_reg, perm_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [W-1:0] out_a_reg, out_b_reg;
  logic [2:0] zone_reg;
  logic zone_valid_reg, srst_reg;
  logic [W-1:0] out_a_next, out_b_next;
  logic [2:0] zone_next;
  logic zone_valid_next, srst_next;
  logic srst_req, srst_active;
  logic gain_apply_enable, perm_on, lsb_on;
  logic [W-1:0] lane_a, lane_b;

  // Word index of a byte address; registers sit at four times their index.
  function automatic logic [7:0] reg_idx(input logic [31:0] a);
    reg_idx = a[9:2];
  endfunction : reg_idx

  // True when the address lands on a mapped register.
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == mdc_pkg::IDX_ZONE_SEL) || (i == mdc_pkg::IDX_GAIN_VAL) ||
      (i == mdc_pkg::IDX_ZONE_CTRL) || (i == mdc_pkg::IDX_GAIN_UNLOCK_A) ||
      (i == mdc_pkg::IDX_UNLOCK_B) || (i == mdc_pkg::IDX_LSB_EN) ||
      (i == mdc_pkg::IDX_LSB_SRC) || (i == mdc_pkg::IDX_SOFT_RST) ||
      (i == mdc_pkg::IDX_REORDER) || (i == mdc_pkg::IDX_STATUS);
  endfunction : mapped

  logic take;
  assign take = hsel && hready && htrans[1];

  // Data phase write into the configuration registers.
  always_comb begin
    zone_sel_next = zone_sel_reg;
    gain_next = gain_reg;
    zone_ctrl_next = zone_ctrl_reg;
    unlock_a_next = unlock_a_reg;
    unlock_b_next = unlock_b_reg;
    lsb_en_next = lsb_en_reg;
    lsb_src_next = lsb_src_reg;
    perm_next = output_bit_permutation_reg;
    srst_req = 1'b0;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        mdc_pkg::IDX_ZONE_SEL: zone_sel_next = {5'h00, hwdata[2:0]};
        mdc_pkg::IDX_GAIN_VAL: gain_next = {1'b0, hwdata[6:0]};
        mdc_pkg::IDX_ZONE_CTRL: zone_ctrl_next = {hwdata[7], 7'h00};
        mdc_pkg::IDX_GAIN_UNLOCK_A: unlock_a_next = {hwdata[7], 6'h00, hwdata[0]};
        mdc_pkg::IDX_UNLOCK_B: unlock_b_next = {4'h0, hwdata[3], 3'h0};
        mdc_pkg::IDX_LSB_EN: lsb_en_next = {7'h00, hwdata[0]};
        mdc_pkg::IDX_LSB_SRC: lsb_src_next = {6'h00, hwdata[1:0]};
        mdc_pkg::IDX_SOFT_RST: srst_req = hwdata[mdc_pkg::SOFT_RST_BIT];
        mdc_pkg::IDX_REORDER: perm_next = hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Address phase capture and read data for the next phase; write-only bits read as zero.
  always_comb begin
    wr_pend_next = take && hwrite;
    wr_addr_next = reg_idx(haddr);
    hrdata_next = 32'h0000_0000;
    if (take && !hwrite && mapped(reg_idx(haddr))) begin
      unique case (reg_idx(haddr))
        mdc_pkg::IDX_ZONE_SEL: hrdata_next = {24'h000000, zone_sel_reg};
        mdc_pkg::IDX_GAIN_VAL: hrdata_next = {24'h000000, gain_reg};
        mdc_pkg::IDX_ZONE_CTRL: hrdata_next = {24'h000000, zone_ctrl_reg};
        mdc_pkg::IDX_GAIN_UNLOCK_A: hrdata_next = {31'h0, unlock_a_reg[0]};
        mdc_pkg::IDX_LSB_EN: hrdata_next = {24'h000000, lsb_en_reg};
        mdc_pkg::IDX_LSB_SRC: hrdata_next = {24'h000000, lsb_src_reg};
        mdc_pkg::IDX_REORDER: hrdata_next = {24'h000000, output_bit_permutation_reg};
        mdc_pkg::IDX_STATUS: hrdata_next = {27'h0, lsb_on, perm_on, gain_apply_enable,
          zone_valid_reg, srst_active};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register the configuration.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zone_sel_reg <= mdc_pkg::RESET_BYTE;
      gain_reg <= mdc_pkg::RESET_BYTE;
      zone_ctrl_reg <= mdc_pkg::RESET_BYTE;
      unlock_a_reg <= mdc_pkg::RESET_BYTE;
      unlock_b_reg <= mdc_pkg::RESET_BYTE;
      lsb_en_reg <= mdc_pkg::RESET_BYTE;
      lsb_src_reg <= mdc_pkg::RESET_BYTE;
      output_bit_permutation_reg <= mdc_pkg::RESET_BYTE;
    end else begin
      zone_sel_reg <= zone_sel_next;
      gain_reg <= gain_next;
      zone_ctrl_reg <= zone_ctrl_next;
      unlock_a_reg <= unlock_a_next;
      unlock_b_reg <= unlock_b_next;
      lsb_en_reg <= lsb_en_next;
      lsb_src_reg <= lsb_src_next;
      output_bit_permutation_reg <= perm_next;
    end
  end

  // Register the bus capture and the read data.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata_reg <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      hrdata_reg <= hrdata_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
    end
  end

  // Stretch the soft reset request.
  mdc_soft_reset u_srst (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(srst_req),
    .active(srst_active)
  );

  // Effective enables.
  assign gain_apply_enable = unlock_a_reg[mdc_pkg::GAIN_EN_BIT];
  assign perm_on = unlock_a_reg[mdc_pkg::UNLOCK_A_BIT] &&
    unlock_b_reg[mdc_pkg::UNLOCK_B_BIT];
  assign lsb_on = lsb_en_reg[mdc_pkg::LSB_EN_BIT] &&
    (lsb_src_reg[1:0] == mdc_pkg::LSB_SRC_OVR_FLAG);

  // Per-channel datapaths.
  mdc_lane #(.W(W)) u_lane_a (
    .din(sample_a), .ovr(ovr_a), .gain_on(gain_apply_enable), .gain(gain_reg[6:0]),
    .perm_on(perm_on), .perm(output_bit_permutation_reg), .lsb_on(lsb_on), .dout(lane_a)
  );
  mdc_lane #(.W(W)) u_lane_b (
    .din(sample_b), .ovr(ovr_b), .gain_on(gain_apply_enable), .gain(gain_reg[6:0]),
    .perm_on(perm_on), .perm(output_bit_permutation_reg), .lsb_on(lsb_on), .dout(lane_b)
  );

  // Next outputs; soft reset clears the datapath but not the zone logic.
  always_comb begin
    srst_next = srst_active;
    out_a_next = srst_active ? '0 : lane_a;
    out_b_next = srst_active ? '0 : lane_b;
    zone_next = mdc_pkg::ZONE_FIRST;
    if (zone_ctrl_reg[mdc_pkg::ZONE_EN_BIT]) begin
      zone_next = zone_sel_reg[2:0];
    end
    zone_valid_next = zone_ctrl_reg[mdc_pkg::ZONE_EN_BIT] &&
      (zone_sel_reg[2:0] == mdc_pkg::ZONE_FIRST ||
       zone_sel_reg[2:0] == mdc_pkg::ZONE_SECOND ||
       zone_sel_reg[2:0] == mdc_pkg::ZONE_THIRD);
  end

  // Output registers, so every output except the tied hreadyout and hresp leaves from a flip-flop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_a_reg <= '0;
      out_b_reg <= '0;
      zone_reg <= mdc_pkg::ZONE_FIRST;
      zone_valid_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= srst_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      zone_reg <= zone_next;
      zone_valid_reg <= zone_valid_next;
    end
  end

  assign out_a = out_a_reg;
  assign out_b = out_b_reg;
  assign nyquist_zone = zone_reg;
  assign zone_valid = zone_valid_reg;
  assign digital_block_soft_reset = srst_reg;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  a_zone_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !zone_ctrl_reg[7] |=> nyquist_zone == 3'h0) else $error("zone used while disabled");
  a_zone_legal: assert property (@(posedge clk_sys) disable iff (rst)
    zone_valid |-> nyquist_zone <= 3'h2) else $error("illegal zone flagged valid");
  a_gain_off: assert property (@(posedge clk_sys) disable iff (rst)
    !unlock_a_reg[0] && !perm_on && !lsb_on && !srst_active |=> out_a == $past(sample_a))
    else $error("gain applied while disabled");
  // Without both unlock bits the sample passes in its own bit order.
  a_perm_lock: assert property (@(posedge clk_sys) disable iff (rst)
    !(unlock_a_reg[7] && unlock_b_reg[3]) && !unlock_a_reg[0] && !lsb_on && !srst_active
    |=> out_b == $past(sample_b)) else $error("permutation applied while locked");
  // With the override enable clear the LSB is the sample's own.
  a_lsb_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !lsb_en_reg[0] && !unlock_a_reg[0] && !perm_on && !srst_active
    |=> out_a[0] == $past(sample_a[0])) else $error("lsb source used while disabled");
  // Only source code 11 moves the overrange flag into the LSB.
  a_lsb_src: assert property (@(posedge clk_sys) disable iff (rst)
    lsb_src_reg[1:0] != 2'h3 && !unlock_a_reg[0] && !perm_on && !srst_active
    |=> out_a[0] == $past(sample_a[0])) else $error("lsb replaced without source 11");
  a_lsb_flag: assert property (@(posedge clk_sys) disable iff (rst)
    lsb_on && !srst_active |=> out_b[0] == $past(ovr_b)) else $error("lsb not overrange");
  a_srst_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    srst_req |=> srst_active [*2] ##1 (!srst_active || $past(srst_req)))
    else $error("soft reset pulse length wrong");
  // The largest gain drives a full-scale positive sample into saturation.
  a_gain_max: assert property (@(posedge clk_sys) disable iff (rst)
    unlock_a_reg[0] && gain_reg[6:0] == 7'h7F && !perm_on && !lsb_on && !srst_active &&
    sample_a == {1'b0, {(W-1){1'b1}}} |=> out_a == {1'b0, {(W-1){1'b1}}})
    else $error("largest gain does not saturate");
  // Soft reset zeroes the datapath, leaves the zone logic alone and reads back as zero.
  a_srst_zero: assert property (@(posedge clk_sys) disable iff (rst)
    srst_active |=> out_a == '0 && out_b == '0) else $error("datapath not cleared");
  a_srst_zone: assert property (@(posedge clk_sys) disable iff (rst)
    srst_active && zone_ctrl_reg[7] |=> nyquist_zone == $past(zone_sel_reg[2:0]))
    else $error("soft reset disturbed the zone");
  a_srst_read: assert property (@(posedge clk_sys) disable iff (rst)
    take && !hwrite && reg_idx(haddr) == mdc_pkg::IDX_SOFT_RST |=> hrdata == 32'h0000_0000)
    else $error("soft reset bit reads nonzero");
  // An enabled zone passes through, and a legal code is flagged valid.
  a_zone_pass: assert property (@(posedge clk_sys) disable iff (rst)
    zone_ctrl_reg[7] |=> nyquist_zone == $past(zone_sel_reg[2:0]))
    else $error("enabled zone not applied");
  a_zone_set: assert property (@(posedge clk_sys) disable iff (rst)
    zone_ctrl_reg[7] && zone_sel_reg[2:0] <= 3'h2 |=> zone_valid)
    else $error("legal zone not flagged valid");
  // Unmapped addresses read as zero.
  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (rst)
    take && !hwrite && !mapped(reg_idx(haddr)) |=> hrdata == 32'h0000_0000)
    else $error("unmapped address reads nonzero");
endmodule : mdc_regs

// *** core/mdc_pkg.sv ***
package mdc_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_ZONE_SEL = 8'h42;
  localparam logic [7:0] IDX_GAIN_VAL = 8'h44;
  localparam logic [7:0] IDX_ZONE_CTRL = 8'h4E;
  localparam logic [7:0] IDX_GAIN_UNLOCK_A = 8'h52;
  localparam logic [7:0] IDX_UNLOCK_B = 8'h72;
  localparam logic [7:0] IDX_LSB_EN = 8'hAB;
  localparam logic [7:0] IDX_LSB_SRC = 8'hAD;
  localparam logic [7:0] IDX_SOFT_RST = 8'hF7;
  localparam logic [7:0] IDX_REORDER = 8'h80;
  localparam logic [7:0] IDX_STATUS = 8'h81;
  // Field positions.
  localparam int ZONE_EN_BIT = 7;
  localparam int GAIN_EN_BIT = 0;
  localparam int UNLOCK_A_BIT = 7;
  localparam int UNLOCK_B_BIT = 3;
  localparam int LSB_EN_BIT = 0;
  localparam int SOFT_RST_BIT = 0;
  // Values after reset.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Zone codes and source codes.
  localparam logic [2:0] ZONE_FIRST = 3'h0;
  localparam logic [2:0] ZONE_SECOND = 3'h1;
  localparam logic [2:0] ZONE_THIRD = 3'h2;
  localparam logic [1:0] LSB_SRC_DATA = 2'h0;
  localparam logic [1:0] LSB_SRC_OVR_FLAG = 2'h3;
  // Gain divisor is 32, a right shift of five.
  localparam int GAIN_SHIFT = 5;
  // Cycles the soft reset pulse lasts.
  localparam logic [1:0] SOFT_RST_CYCLES = 2'h2;
endpackage : mdc_pkg

// *** core/mdc_soft_reset.sv ***
`timescale 1ns/1ns
// Stretches a soft reset request into a fixed pulse that then clears itself.
module mdc_soft_reset (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic req, // One-cycle request.
  output logic active // High while the soft reset lasts.
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  // Load the count on request, else count down to zero.
  always_comb begin
    cnt_next = cnt_reg;
    if (req) begin
      cnt_next = mdc_pkg::SOFT_RST_CYCLES;
    end else if (cnt_reg != 2'h0) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  // Register the count.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign active = (cnt_reg != 2'h0);
endmodule : mdc_soft_reset

// *** core/mdc_lane.sv ***
`timescale 1ns/1ns
// Datapath for one channel: gain, bit permutation and LSB override.
module mdc_lane #(
  parameter int W = 16 // Sample width.
) (
  input wire logic [W-1:0] din, // Input sample.
  input wire logic ovr, // Fast overrange flag of this channel.
  input wire logic gain_on, // Gain applies.
  input wire logic [6:0] gain, // Gain value G.
  input wire logic perm_on, // Permutation applies.
  input wire logic [7:0] perm, // Permutation field.
  input wire logic lsb_on, // LSB override applies.
  output logic [W-1:0] dout // Processed sample.
);
  logic signed [W+7:0] prod;
  logic signed [W+7:0] scaled;
  logic [W-1:0] gained;
  logic [W-1:0] permed;

  // Scale by G/32 and saturate to the sample range.
  always_comb begin
    prod = $signed(din) * $signed({1'b0, gain});
    scaled = prod >>> mdc_pkg::GAIN_SHIFT;
    if (!gain_on) begin
      gained = din;
    end else if (scaled > $signed({{8{1'b0}}, 1'b0, {(W-1){1'b1}}})) begin
      gained = {1'b0, {(W-1){1'b1}}};
    end else if (scaled < $signed({{8{1'b1}}, 1'b1, {(W-1){1'b0}}})) begin
      gained = {1'b1, {(W-1){1'b0}}};
    end else begin
      gained = scaled[W-1:0];
    end
  end

  // Swap the two bits of each adjacent bit pair whose field bit is set.
  always_comb begin
    permed = gained;
    for (int i = 0; i < 8; i++) begin
      if (perm_on && perm[i]) begin
        permed[2*i] = gained[2*i+1];
        permed[2*i+1] = gained[2*i];
      end
    end
  end

  // Replace the LSB with the overrange flag when selected.
  always_comb begin
    dout = permed;
    if (lsb_on) begin
      dout[0] = ovr;
    end
  end
endmodule : mdc_lane

// *** dv/adc_main_digital_control_regs_tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the control register bank and its datapath.
module adc_main_digital_control_regs_tb;
  logic clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ovr_a = 1'b0, ovr_b = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, nyquist_zone;
  logic hreadyout, hresp, zone_valid, digital_block_soft_reset;
  logic [15:0] sample_a = 16'h0, sample_b = 16'h0, out_a, out_b;
  logic [31:0] lfsr = 32'h0E6895FA;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  logic [7:0] perm, cfg;
  logic [6:0] gain;

  mdc_regs dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_a(sample_a), .sample_b(sample_b),
    .ovr_a(ovr_a), .ovr_b(ovr_b), .out_a(out_a), .out_b(out_b), .nyquist_zone(nyquist_zone),
    .zone_valid(zone_valid), .digital_block_soft_reset(digital_block_soft_reset));

  // Clock at 125 MHz.
  always #4 clk_sys = ~clk_sys;

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // Next value of the pseudo-random sequence.
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'hA3000000 : 32'h0);
  endfunction : nxt

  // Expected lane output: gain, then pair swaps, then the overrange LSB.
  function automatic logic [15:0] exp_lane(input logic [15:0] d, input logic o, input logic [7:0] c,
      input logic [6:0] g, input logic [7:0] p);
    logic signed [23:0] m;
    logic [15:0] r;
    r = d;
    if (c[0]) begin
      m = ($signed(d) * $signed({1'b0, g})) >>> 5;
      r = (m > 32767) ? 16'h7FFF : (m < -32768) ? 16'h8000 : m[15:0];
    end
    if (c[1] && c[2]) begin
      for (int i = 0; i < 8; i++) begin
        if (p[i]) begin
          r[2*i+1 -: 2] = {r[2*i], r[2*i+1]};
        end
      end
    end
    if (c[3] && c[5:4] == 2'h3) begin
      r[0] = o;
    end
    return r;
  endfunction : exp_lane

  // Compares one value and counts the result.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  // One single-word transfer: address phase, then data phase.
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer

  // Writes a byte register.
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    xfer(idx, 1'b1, {24'h0, v});
  endtask : wr

  // Reads a register and compares it.
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 32'h0);
    chk("readback", rv, {24'h0, exp});
  endtask : rdchk

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Main sequence.
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    // Reset values of three registers, and the masks of write-only bits.
    rdchk(mdc_pkg::IDX_ZONE_CTRL, 8'h00);
    rdchk(mdc_pkg::IDX_GAIN_UNLOCK_A, 8'h00);
    rdchk(mdc_pkg::IDX_LSB_SRC, 8'h00);
    wr(mdc_pkg::IDX_GAIN_UNLOCK_A, 8'h81);
    rdchk(mdc_pkg::IDX_GAIN_UNLOCK_A, 8'h01);
    wr(mdc_pkg::IDX_UNLOCK_B, 8'h08);
    rdchk(mdc_pkg::IDX_UNLOCK_B, 8'h00);
    rdchk(mdc_pkg::IDX_STATUS, 8'h0C);
    wr(8'h10, 8'h5A);
    rdchk(8'h10, 8'h00);
    // Every zone code with the enable off and on.
    for (int k = 0; k < 16; k++) begin
      wr(mdc_pkg::IDX_ZONE_SEL, {5'h0, k[2:0]});
      wr(mdc_pkg::IDX_ZONE_CTRL, {k[3], 7'h0});
      repeat (3) @(posedge clk_sys);
      chk("zone_valid", {31'h0, zone_valid}, {31'h0, k[3] && k[2:0] < 3});
      if (!k[3] || k[2:0] < 3) begin
        chk("nyquist_zone", {29'h0, nyquist_zone}, k[3] ? {29'h0, k[2:0]} : 32'h0);
      end
    end
    // Random configurations; the first round is a saturating corner.
    for (int r = 0; r < 14; r++) begin
      lfsr = nxt(lfsr);
      cfg = (r == 0) ? 8'h01 : lfsr[7:0];
      gain = (r == 0) ? 7'h7F : lfsr[14:8];
      perm = lfsr[23:16];
      wr(mdc_pkg::IDX_GAIN_VAL, {1'b0, gain});
      wr(mdc_pkg::IDX_GAIN_UNLOCK_A, {cfg[1], 6'h0, cfg[0]});
      wr(mdc_pkg::IDX_UNLOCK_B, {4'h0, cfg[2], 3'h0});
      wr(mdc_pkg::IDX_REORDER, perm);
      wr(mdc_pkg::IDX_LSB_EN, {7'h0, cfg[3]});
      wr(mdc_pkg::IDX_LSB_SRC, {6'h0, cfg[5:4]});
      for (int j = 0; j < 6; j++) begin
        lfsr = nxt(lfsr);
        sample_a <= (r == 0 && j == 0) ? 16'h7FFF : lfsr[15:0];
        sample_b <= (r == 0 && j == 0) ? 16'h8000 : lfsr[31:16];
        ovr_a <= lfsr[3];
        ovr_b <= lfsr[20];
        @(posedge clk_sys);
        #1;
        chk("out_a", {16'h0, out_a}, {16'h0, exp_lane(sample_a, ovr_a, cfg, gain, perm)});
        chk("out_b", {16'h0, out_b}, {16'h0, exp_lane(sample_b, ovr_b, cfg, gain, perm)});
        @(posedge clk_sys);
      end
    end
    // Soft reset: a pulse of fixed length, zero out_a, bit clears itself.
    sample_a <= 16'h1234;
    wr(mdc_pkg::IDX_GAIN_UNLOCK_A, 8'h00);
    wr(mdc_pkg::IDX_LSB_EN, 8'h00);
    wr(mdc_pkg::IDX_SOFT_RST, 8'h01);
    n = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (digital_block_soft_reset === 1'b1) begin
        n++;
        chk("out_a", {16'h0, out_a}, 32'h0);
      end
    end
    chk("out_a", {16'h0, out_a}, 32'h0000_1234);
    @(posedge clk_sys);
    chk("soft reset length", n, {30'h0, mdc_pkg::SOFT_RST_CYCLES});
    rdchk(mdc_pkg::IDX_SOFT_RST, 8'h00);
    rdchk(mdc_pkg::IDX_GAIN_VAL, {1'b0, gain});
    rdchk(mdc_pkg::IDX_REORDER, perm);
    rdchk(mdc_pkg::IDX_LSB_EN, 8'h00);
    end_of_test();
  end
endmodule : adc_main_digital_control_regs_tb
